// file: tw_fifo2.sv
`timescale 1ns/10ps
module tw_fifo2 #(
  parameter int W = 8
) (
  input  wire logic clk,
  input  wire logic rst_n,
  tw_strm_if.snk    in_if,
  tw_strm_if.src    out_if
);

  logic         head_v_r;
  logic [W-1:0] head_d_r;
  logic         tail_v_r;
  logic [W-1:0] tail_d_r;

  wire push = in_if.valid & ~tail_v_r;
  wire pop  = head_v_r & out_if.ready;

  assign in_if.ready  = ~tail_v_r;
  assign out_if.valid = head_v_r;
  assign out_if.data  = head_d_r;

  // The head entry drives the output directly; the tail catches a word during a stall.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      head_v_r <= 1'b0;
      head_d_r <= '0;
      tail_v_r <= 1'b0;
      tail_d_r <= '0;
    end else if (pop && tail_v_r) begin
      head_d_r <= tail_d_r;
      tail_v_r <= 1'b0;
    end else if (pop) begin
      head_v_r <= push;
      head_d_r <= in_if.data;
    end else if (push && head_v_r) begin
      tail_v_r <= 1'b1;
      tail_d_r <= in_if.data;
    end else if (push) begin
      head_v_r <= 1'b1;
      head_d_r <= in_if.data;
    end
  end

endmodule : tw_fifo2

// file: tw_master.sv
// What this block does
// - While the power-reduce input is high the block is idle and releases both lines.
// - Lines are only pulled low or released; the level is read back from the wire.
// - SDA changes only while SCL is held low, except for START and STOP.
// - START and STOP are SDA edges while SCL is high, also seen from others.
// - Bus counts as busy from any START until STOP; no START while busy unless this master owns the bus.
// - A repeated START keeps the bus owned and busy until the next STOP.
// - An address packet is seven address bits, direction bit, acknowledge bit.
// - Direction bit one reads from the slave, zero writes to it.
// - After an unacknowledged address the master sends STOP.
// - The address byte is shifted out most significant bit first.
// - All-zero address with write bit is general call, then data follows.
// - General call with read bit is refused and never sent.
// - Addresses 1111xxx are reserved and refused.
// - A data packet is eight bits, most significant first, then acknowledge.
// - The receiver pulls SDA low in the ninth clock to acknowledge, else NACK.
// - When reading, the last byte is answered with NACK.
// - A master drives SCL and makes START and STOP; a slave only holds SCL low.
// - START with STOP and no data packet is refused.
// - A slave may stretch SCL low; the master waits for release.
`timescale 1ns/10ps
module tw_master (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       serial_if_power_reduce,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_start,
  input  wire logic       cmd_stop,
  input  wire logic       cmd_nack,
  input  wire logic [7:0] cmd_data,
  output logic            rsp_valid,
  input  wire logic       rsp_ready,
  output logic [7:0]      rsp_data,
  output logic            rsp_ack_n,
  output logic            rsp_err,
  output logic            bus_busy,
  output logic            bus_owned
);

  localparam int TW = tw_pkg::TMR_W;

  tw_pkg::tw_state_e state_r;
  tw_pkg::tw_state_e state_nxt;

  logic [TW-1:0] tmr_r;
  logic [TW-1:0] tmr_nxt;
  logic [3:0]    bit_r;
  logic [8:0]    tx_r;
  logic [8:0]    rx_r;
  logic          stop_r;
  logic          is_addr_r;
  logic          rd_mode_r;
  logic          own_r;
  logic          err_r;
  logic          busy_r;
  logic          scl_d_r;
  logic          sda_d_r;
  logic          scl_oe_r;
  logic          scl_oe_nxt;
  logic          sda_oe_r;
  logic          sda_oe_nxt;
  logic          cmd_ready_r;
  logic          scl_o_r;
  logic          sda_o_r;
  logic          scl_s;
  logic          sda_s;

  tw_strm_if #(.W(tw_pkg::RSP_W)) rsp_in ();
  tw_strm_if #(.W(tw_pkg::RSP_W)) rsp_out ();

  tw_sync #(.N(2)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d_in  ({scl_i, sda_i}),
    .d_out ({scl_s, sda_s})
  );

  tw_fifo2 #(.W(tw_pkg::RSP_W)) u_rsp_buf (
    .clk    (clk),
    .rst_n  (rst_n),
    .in_if  (rsp_in.snk),
    .out_if (rsp_out.src)
  );

  // States in which this master holds SCL low.
  function automatic logic scl_low_in(input tw_pkg::tw_state_e st, input logic own);
    scl_low_in = (st == tw_pkg::ST_BIT_LOW) || (st == tw_pkg::ST_RS_LOW) ||
                 (st == tw_pkg::ST_STOP_A) ||
                 (own && ((st == tw_pkg::ST_FETCH) || (st == tw_pkg::ST_RSP)));
  endfunction : scl_low_in

  // States whose timing may only run while SCL reads high.
  function automatic logic wants_high(input tw_pkg::tw_state_e st);
    wants_high = (st == tw_pkg::ST_START_A) || (st == tw_pkg::ST_BIT_HIGH) ||
                 (st == tw_pkg::ST_STOP_B);
  endfunction : wants_high

  function automatic logic [TW-1:0] phase_len(input tw_pkg::tw_state_e st);
    unique case (st)
      tw_pkg::ST_RS_LOW:   phase_len = tw_pkg::CYC_LOW;
      tw_pkg::ST_START_A:  phase_len = tw_pkg::CYC_SU_STA;
      tw_pkg::ST_START_B:  phase_len = tw_pkg::CYC_HD_STA;
      tw_pkg::ST_BIT_LOW:  phase_len = tw_pkg::CYC_LOW;
      tw_pkg::ST_BIT_HIGH: phase_len = tw_pkg::CYC_HIGH;
      tw_pkg::ST_STOP_A:   phase_len = tw_pkg::CYC_LOW;
      tw_pkg::ST_STOP_B:   phase_len = tw_pkg::CYC_SU_STO;
      tw_pkg::ST_STOP_C:   phase_len = tw_pkg::CYC_BUF;
      default:             phase_len = '0;
    endcase
  endfunction : phase_len

  wire       enabled   = ~serial_if_power_reduce;
  wire       cmd_take  = cmd_valid & cmd_ready_r;
  wire [6:0] cmd_addr  = cmd_data[7:1];
  wire       gc_read   = cmd_start & (cmd_addr == tw_pkg::ADDR_GC) & cmd_data[0];
  wire       rsv_addr  = cmd_start & (cmd_addr[6:3] == tw_pkg::ADDR_RSV_HI);
  wire       no_data   = cmd_start & cmd_stop;
  wire       no_owner  = ~cmd_start & ~own_r;
  wire       cmd_bad   = gc_read | rsv_addr | no_data | no_owner;
  wire       last_nack = cmd_nack | cmd_stop;

  // Address byte, or a write byte, goes out MSB first with SDA released for the ack.
  wire [8:0] tx_load   = (cmd_start | ~rd_mode_r) ? {cmd_data, 1'b1} : {8'hFF, last_nack};

  // Waiting for SCL covers stretching by a slave; waiting for bus_free covers another master's START.
  wire       bus_free  = own_r | ~busy_r;
  wire       start_ok  = (state_r != tw_pkg::ST_START_A) | bus_free;
  wire       line_ok   = (scl_s | ~wants_high(state_r)) & start_ok;
  wire       tmr_zero  = (tmr_r == '0);
  wire       done      = tmr_zero & line_ok;
  wire       last_bit  = (bit_r == tw_pkg::BIT_LAST);
  wire       addr_nack = is_addr_r & rx_r[0];
  wire       start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire       stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire       st_change = (state_nxt != state_r);

  assign rsp_in.valid = (state_r == tw_pkg::ST_RSP);
  assign rsp_in.data  = {err_r, rx_r[0], rx_r[8:1]};
  assign rsp_out.ready = rsp_ready;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      tw_pkg::ST_IDLE: begin
        if (cmd_take) begin
          state_nxt = cmd_bad ? tw_pkg::ST_RSP : tw_pkg::ST_START_A;
        end
      end
      tw_pkg::ST_FETCH: begin
        if (cmd_take && cmd_bad) begin
          state_nxt = tw_pkg::ST_RSP;
        end else if (cmd_take && cmd_start) begin
          state_nxt = tw_pkg::ST_RS_LOW;
        end else if (cmd_take) begin
          state_nxt = tw_pkg::ST_BIT_LOW;
        end
      end
      tw_pkg::ST_RS_LOW: begin
        if (done) begin
          state_nxt = tw_pkg::ST_START_A;
        end
      end
      tw_pkg::ST_START_A: begin
        if (done) begin
          state_nxt = tw_pkg::ST_START_B;
        end
      end
      tw_pkg::ST_START_B: begin
        if (done) begin
          state_nxt = tw_pkg::ST_BIT_LOW;
        end
      end
      tw_pkg::ST_BIT_LOW: begin
        if (done) begin
          state_nxt = tw_pkg::ST_BIT_HIGH;
        end
      end
      tw_pkg::ST_BIT_HIGH: begin
        if (done) begin
          state_nxt = last_bit ? tw_pkg::ST_RSP : tw_pkg::ST_BIT_LOW;
        end
      end
      tw_pkg::ST_RSP: begin
        if (rsp_in.ready && err_r) begin
          state_nxt = own_r ? tw_pkg::ST_FETCH : tw_pkg::ST_IDLE;
        end else if (rsp_in.ready && (stop_r || addr_nack)) begin
          state_nxt = tw_pkg::ST_STOP_A;
        end else if (rsp_in.ready) begin
          state_nxt = tw_pkg::ST_FETCH;
        end
      end
      tw_pkg::ST_STOP_A: begin
        if (done) begin
          state_nxt = tw_pkg::ST_STOP_B;
        end
      end
      tw_pkg::ST_STOP_B: begin
        if (done) begin
          state_nxt = tw_pkg::ST_STOP_C;
        end
      end
      tw_pkg::ST_STOP_C: begin
        if (done) begin
          state_nxt = tw_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = tw_pkg::ST_IDLE;
      end
    endcase
    if (!enabled) begin
      state_nxt = tw_pkg::ST_IDLE;
    end
  end

  // The phase timer reloads on every state change and holds while line_ok is low: SCL not yet high in a wants_high state, or bus_free low in ST_START_A.
  always_comb begin
    if (st_change) begin
      tmr_nxt = phase_len(state_nxt);
    end else if (line_ok && !tmr_zero) begin
      tmr_nxt = tmr_r - 1'b1;
    end else begin
      tmr_nxt = tmr_r;
    end
  end

  assign scl_oe_nxt = enabled & scl_low_in(state_r, own_r);

  // Data bits move SDA only once SCL has been pulled low; ST_START_B and ST_STOP_C change it under a high clock.
  always_comb begin
    unique case (state_r)
      tw_pkg::ST_IDLE,
      tw_pkg::ST_RS_LOW,
      tw_pkg::ST_START_A,
      tw_pkg::ST_STOP_C:   sda_oe_nxt = 1'b0;
      tw_pkg::ST_START_B,
      tw_pkg::ST_STOP_B:   sda_oe_nxt = 1'b1;
      tw_pkg::ST_BIT_LOW:  sda_oe_nxt = scl_oe_r ? ~tx_r[8] : sda_oe_r;
      tw_pkg::ST_STOP_A:   sda_oe_nxt = scl_oe_r | sda_oe_r;
      default:             sda_oe_nxt = sda_oe_r;
    endcase
    if (!enabled) begin
      sda_oe_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= tw_pkg::ST_IDLE;
      tmr_r   <= '0;
    end else begin
      state_r <= state_nxt;
      tmr_r   <= tmr_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_oe_r    <= 1'b0;
      sda_oe_r    <= 1'b0;
      scl_o_r     <= 1'b0;
      sda_o_r     <= 1'b0;
      cmd_ready_r <= 1'b0;
    end else begin
      scl_oe_r    <= scl_oe_nxt;
      sda_oe_r    <= sda_oe_nxt;
      scl_o_r     <= 1'b0;
      sda_o_r     <= 1'b0;
      cmd_ready_r <= enabled & ((state_nxt == tw_pkg::ST_IDLE) | (state_nxt == tw_pkg::ST_FETCH));
    end
  end

  // Command latch: a good command loads the shifter, a bad one only raises the error and clears bit_r.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_r      <= '1;
      stop_r    <= 1'b0;
      is_addr_r <= 1'b0;
      rd_mode_r <= 1'b0;
      err_r     <= 1'b0;
      bit_r     <= '0;
    end else if (cmd_take) begin
      err_r <= cmd_bad;
      bit_r <= '0;
      if (!cmd_bad) begin
        tx_r      <= tx_load;
        stop_r    <= cmd_stop;
        is_addr_r <= cmd_start;
      end
      if (!cmd_bad && cmd_start) begin
        rd_mode_r <= cmd_data[0];
      end
    end else if (state_r == tw_pkg::ST_BIT_HIGH && done) begin
      tx_r  <= {tx_r[7:0], 1'b1};
      bit_r <= bit_r + 4'h1;
    end
  end

  // Each bit is sampled at the end of its high phase.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_r <= '0;
    end else if (state_r == tw_pkg::ST_BIT_HIGH && done) begin
      rx_r <= {rx_r[7:0], sda_s};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      own_r <= 1'b0;
    end else if (!enabled || (state_r == tw_pkg::ST_STOP_C && done)) begin
      own_r <= 1'b0;
    end else if (state_r == tw_pkg::ST_START_B && done) begin
      own_r <= 1'b1;
    end
  end

  // Busy follows every START and STOP seen on the wire, ours or another master's.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      busy_r  <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      if (stop_det) begin
        busy_r <= 1'b0;
      end else if (start_det) begin
        busy_r <= 1'b1;
      end
    end
  end

  assign scl_o     = scl_o_r;
  assign sda_o     = sda_o_r;
  assign scl_oe    = scl_oe_r;
  assign sda_oe    = sda_oe_r;
  assign cmd_ready = cmd_ready_r;
  assign rsp_valid = rsp_out.valid;
  assign rsp_data  = rsp_out.data[7:0];
  assign rsp_ack_n = rsp_out.data[tw_pkg::RSP_ACK_BIT];
  assign rsp_err   = rsp_out.data[tw_pkg::RSP_ERR_BIT];
  assign bus_busy  = busy_r;
  assign bus_owned = own_r;

endmodule : tw_master

// file: tw_master_bench.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin num_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module tw_master_bench;
  localparam logic [6:0] SLV = 7'h2A;
  localparam logic [7:0] RD  = 8'h96;
  logic clk = 1'b0, rst_n = 1'b0, pwr = 1'b0, gc_en = 1'b0, rsp_ready = 1'b0;
  logic cmd_valid = 1'b0, cmd_start = 1'b0, cmd_stop = 1'b0, cmd_nack = 1'b0;
  logic [7:0] cmd_data = 8'h00, rsp_data, last_byte;
  logic [15:0] stretch_ns = 16'h0;
  logic scl_oe, sda_oe, s_scl_oe, s_sda_oe, cmd_ready, rsp_valid, rsp_ack_n, rsp_err, bus_busy, bus_owned;
  logic scl_o, sda_o;
  int num_errors = 0;
  int comparisons = 0;
  wire scl = ~(scl_oe | s_scl_oe);
  wire sda = ~(sda_oe | s_sda_oe);
  wire [2:0] flags = {bus_owned, rsp_valid, cmd_ready};
  always #4 clk = ~clk;
  tw_master DUT (.clk(clk), .rst_n(rst_n), .serial_if_power_reduce(pwr), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_nack(cmd_nack),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
    .rsp_ack_n(rsp_ack_n), .rsp_err(rsp_err), .bus_busy(bus_busy), .bus_owned(bus_owned));
  tw_slave_model #(.ADDR(SLV), .RD_BYTE(RD)) u_slv (.scl(scl), .sda(sda), .gc_en(gc_en),
    .stretch_ns(stretch_ns), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .last_byte(last_byte));
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic wait_for(input int i, input logic lvl);
    int k;
    k = 0;
    while (flags[i] !== lvl) begin
      @(posedge clk);
      #1;
      k++;
      if (k > 40000) begin
        num_errors++;
        $display("CHECK FAILED wait flag %0d expected %0h seen %0h", i, lvl, flags[i]);
        end_sim();
      end
    end
  endtask : wait_for
  task automatic send(input logic s, input logic p, input logic n, input logic [7:0] d);
    cmd_start = s;
    cmd_stop = p;
    cmd_nack = n;
    cmd_data = d;
    cmd_valid = 1'b1;
    wait_for(0, 1'b1);
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
  endtask : send
  task automatic answer(input logic err, input logic ack_n, input logic [7:0] d);
    wait_for(1, 1'b1);
    `CHK("rsp_err", err, rsp_err)
    if (!err) begin
      `CHK("rsp_ack_n", ack_n, rsp_ack_n)
      `CHK("rsp_data", d, rsp_data)
    end
    rsp_ready = 1'b1;
    @(posedge clk);
    #1;
    rsp_ready = 1'b0;
  endtask : answer
  task automatic t_power();
    pwr = 1'b1;
    cmd_valid = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    `CHK("ready off", 1'b0, cmd_ready)
    `CHK("lines free", 2'h3, {scl, sda})
    cmd_valid = 1'b0;
    pwr = 1'b0;
    wait_for(0, 1'b1);
    $display("t_power done");
  endtask : t_power
  task automatic t_write(input logic [15:0] st);
    stretch_ns = st;
    send(1'b1, 1'b0, 1'b0, {SLV, 1'b0});
    send(1'b0, 1'b1, 1'b0, 8'hC3);
    answer(1'b0, 1'b0, {SLV, 1'b0});
    answer(1'b0, 1'b0, 8'hC3);
    `CHK("slave byte", 8'hC3, last_byte)
    `CHK("pin levels", 2'h0, {scl_o, sda_o})
    wait_for(2, 1'b0);
    `CHK("bus free", 1'b0, bus_busy)
    stretch_ns = 16'h0;
    $display("t_write done");
  endtask : t_write
  task automatic t_read();
    send(1'b1, 1'b0, 1'b0, {SLV, 1'b0});
    answer(1'b0, 1'b0, {SLV, 1'b0});
    send(1'b1, 1'b0, 1'b0, {SLV, 1'b1});
    answer(1'b0, 1'b0, {SLV, 1'b1});
    `CHK("busy on restart", 1'b1, bus_busy)
    send(1'b0, 1'b0, 1'b0, 8'h00);
    answer(1'b0, 1'b0, RD);
    send(1'b0, 1'b0, 1'b1, 8'h00);
    answer(1'b0, 1'b1, RD);
    send(1'b0, 1'b1, 1'b0, 8'h00);
    answer(1'b0, 1'b1, 8'hFF);
    wait_for(2, 1'b0);
    $display("t_read done");
  endtask : t_read
  task automatic t_nack();
    send(1'b1, 1'b0, 1'b0, 8'h22);
    answer(1'b0, 1'b1, 8'h22);
    wait_for(2, 1'b0);
    `CHK("stop after nack", 1'b0, bus_busy)
    $display("t_nack done");
  endtask : t_nack
  task automatic t_gcall();
    gc_en = 1'b1;
    send(1'b1, 1'b0, 1'b0, 8'h00);
    answer(1'b0, 1'b0, 8'h00);
    send(1'b0, 1'b1, 1'b0, 8'h5A);
    answer(1'b0, 1'b0, 8'h5A);
    `CHK("gc byte", 8'h5A, last_byte)
    wait_for(2, 1'b0);
    gc_en = 1'b0;
    $display("t_gcall done");
  endtask : t_gcall
  task automatic t_refuse();
    logic [9:0] tbl [5];
    tbl = '{10'h201, 10'h2FE, 10'h2F1, {2'h3, SLV, 1'b0}, 10'h033};
    for (int i = 0; i < 5; i++) begin
      send(tbl[i][9], tbl[i][8], 1'b0, tbl[i][7:0]);
      answer(1'b1, 1'b0, 8'h00);
      `CHK("no traffic", 1'b0, bus_busy)
    end
    $display("t_refuse done");
  endtask : t_refuse
  initial begin
    repeat (4) @(posedge clk);
    #1;
    `CHK("reset lines", 2'h0, {scl_oe, sda_oe})
    `CHK("reset ready", 1'b0, cmd_ready)
    rst_n = 1'b1;
    t_power();
    t_write(16'h0);
    t_write(16'h0BB8);
    t_read();
    t_nack();
    t_gcall();
    t_refuse();
    end_sim();
  end
endmodule : tw_master_bench

// file: tw_master_checker.sv
`timescale 1ns/10ps
module tw_master_checker (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       serial_if_power_reduce,
  input wire logic       scl_i,
  input wire logic       scl_oe,
  input wire logic       sda_i,
  input wire logic       sda_oe,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic       cmd_start,
  input wire logic       cmd_stop,
  input wire logic [7:0] cmd_data,
  input wire logic       rsp_valid,
  input wire logic       rsp_err,
  input wire logic       bus_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] lo_r;
  logic [7:0] rel_r;
  logic [7:0] hi_r;
  wire        pwr     = serial_if_power_reduce;
  wire        take    = cmd_valid && cmd_ready;
  wire        bad_adr = cmd_start && (cmd_stop || cmd_data == 8'h01 || cmd_data[7:4] == 4'hF);
  // Saturating counts of SCL held low, SCL released, and SCL seen high.
  wire [7:0]  lo_nxt  = scl_oe ? lo_r + {7'h00, ~&lo_r} : 8'h00;
  wire [7:0]  rel_nxt = !scl_oe ? rel_r + {7'h00, ~&rel_r} : 8'h00;
  wire [7:0]  hi_nxt  = scl_i ? hi_r + {7'h00, ~&hi_r} : 8'h00;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_r  <= 8'h00;
      rel_r <= 8'hFF;
      hi_r  <= 8'h00;
    end else begin
      lo_r  <= lo_nxt;
      rel_r <= rel_nxt;
      hi_r  <= hi_nxt;
    end
  end
  sequence s_quiet;
    (!scl_oe && !sda_oe) [*6];
  endsequence
  sequence s_refused;
    ##[1:8] (rsp_valid && rsp_err);
  endsequence
  a_refuse_quiet: assert property (take && bad_adr && !bus_busy |=> s_quiet)
    else $error("refused command moved a line");
  a_refuse_err: assert property (take && bad_adr |-> s_refused)
    else $error("refused command gave no error answer");
  a_take_drops: assert property (take |=> !cmd_ready)
    else $error("ready stayed high after a take");
  a_low_time: assert property ($fell(scl_oe) && !$past(pwr) |-> lo_r >= 8'hA3)
    else $error("clock low phase too short");
  a_high_time: assert property ($rose(scl_oe) |-> hi_r >= 8'h96)
    else $error("clock pulled low before high time seen");
  a_sda_set_up: assert property ($changed(sda_oe) && !scl_oe && !$past(pwr) |-> rel_r >= 8'h4B)
    else $error("data changed while clock high");
  a_busy_start: assert property ($fell(sda_i) && scl_i && $past(scl_i) |-> ##[1:6] bus_busy)
    else $error("start not seen as busy");
  a_idle_stop: assert property ($rose(sda_i) && scl_i && $past(scl_i) && !pwr |-> ##[1:6] !bus_busy)
    else $error("stop not seen as free");
  a_busy_drop: assert property ($fell(bus_busy) && !$past(pwr) |-> sda_i && scl_i)
    else $error("busy dropped without a stop");
  a_power_off: assert property (pwr [*2] |-> !scl_oe && !sda_oe && !cmd_ready)
    else $error("block active while powered down");
endmodule : tw_master_checker
bind tw_master tw_master_checker u_chk (.*);

// file: tw_pkg.sv
package tw_pkg;

  localparam int CLK_MHZ     = 125;
  localparam int T_LOW_NS    = 1300;
  localparam int T_HIGH_NS   = 1200;
  localparam int T_SU_STA_NS = 600;
  localparam int T_HD_STA_NS = 600;
  localparam int T_SU_STO_NS = 600;
  localparam int T_BUF_NS    = 1300;

  localparam int TMR_W = 8;

  // Least times, rounded up to whole clock cycles.
  // The long high time keeps a whole bit at 2.5 us or more, since no rise time adds to it.
  localparam logic [TMR_W-1:0] CYC_LOW    = TMR_W'((T_LOW_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] CYC_HIGH   = TMR_W'((T_HIGH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] CYC_SU_STA = TMR_W'((T_SU_STA_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] CYC_HD_STA = TMR_W'((T_HD_STA_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] CYC_SU_STO = TMR_W'((T_SU_STO_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] CYC_BUF    = TMR_W'((T_BUF_NS * CLK_MHZ + 999) / 1000);

  localparam logic [3:0] BIT_LAST    = 4'h8;
  localparam logic [6:0] ADDR_GC     = 7'h00;
  localparam logic [3:0] ADDR_RSV_HI = 4'hF;

  // Answer word: error flag, acknowledge bit, byte.
  localparam int RSP_W       = 10;
  localparam int RSP_ERR_BIT = 9;
  localparam int RSP_ACK_BIT = 8;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_START_A  = 4'h1,
    ST_START_B  = 4'h2,
    ST_BIT_LOW  = 4'h3,
    ST_BIT_HIGH = 4'h4,
    ST_FETCH    = 4'h5,
    ST_RSP      = 4'h6,
    ST_RS_LOW   = 4'h7,
    ST_STOP_A   = 4'h8,
    ST_STOP_B   = 4'h9,
    ST_STOP_C   = 4'hA
  } tw_state_e;

endpackage : tw_pkg

// file: tw_slave_model.sv
`timescale 1ns/10ps
module tw_slave_model #(
  parameter logic [6:0] ADDR    = 7'h2A,
  parameter logic [7:0] RD_BYTE = 8'h96
) (
  input wire logic        scl,
  input wire logic        sda,
  input wire logic        gc_en,
  input wire logic [15:0] stretch_ns,
  output logic            scl_oe,
  output logic            sda_oe,
  output logic [7:0]      last_byte
);
  logic [7:0] sh_r = 8'h00;
  logic [3:0] cnt_r = 4'h0;
  logic       adr_r = 1'b0;
  logic       hit_r = 1'b0;
  logic       rd_r = 1'b0;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    last_byte = 8'h00;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    cnt_r = 4'h0;
    adr_r = 1'b1;
    hit_r = 1'b0;
    rd_r  = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    hit_r = 1'b0;
    rd_r  = 1'b0;
  end
  always @(posedge scl) begin
    if (cnt_r == 4'h8) begin
      cnt_r = 4'h0;
      adr_r = 1'b0;
      if (rd_r && sda) hit_r = 1'b0;
    end else begin
      sh_r  = {sh_r[6:0], sda};
      cnt_r = cnt_r + 4'h1;
    end
  end
  // Lines are only pulled low; every change happens while SCL is low.
  always @(negedge scl) begin
    if (cnt_r == 4'h8 && adr_r) begin
      hit_r  = sh_r[7:1] == ADDR || (sh_r == 8'h00 && gc_en);
      rd_r   = hit_r && sh_r[0];
      sda_oe = hit_r;
    end else if (cnt_r == 4'h8) begin
      sda_oe = hit_r && !rd_r;
      if (sda_oe) last_byte = sh_r;
    end else
      sda_oe = hit_r && rd_r && !RD_BYTE[3'h7 - cnt_r[2:0]];
    if (stretch_ns != 16'h0 && hit_r) begin
      scl_oe = 1'b1;
      #(stretch_ns) scl_oe = 1'b0;
    end
  end
endmodule : tw_slave_model

// file: tw_strm_if.sv
`timescale 1ns/10ps
interface tw_strm_if #(
  parameter int W = 8
) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : tw_strm_if

// file: tw_sync.sv
`timescale 1ns/10ps
module tw_sync #(
  parameter int N = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] d_in,
  output logic      [N-1:0] d_out
);

  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;

  // Released open-drain lines idle high, so both stages reset high.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {N{1'b1}};
      sync_r <= {N{1'b1}};
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign d_out = sync_r;

endmodule : tw_sync
